// ===== rtl/rwd_top.sv
module rwd_top
    import rwd_pkg::*;
(
    input  logic        clk_i,
    input  logic        nrst_i,
    input  logic        psel_i,
    input  logic        penable_i,
    input  logic        pwrite_i,
    input  logic [7:0]  paddr_i,
    input  logic [31:0] pwdata_i,
    input  logic [3:0]  pstrb_i,
    output logic [31:0] prdata_o,
    output logic        pready_o,
    output logic        pslverr_o,
    input  logic [7:0]  hours_i,
    input  logic [7:0]  month_i,
    input  logic [2:0]  dow_i,
    input  logic [7:0]  mday_i,
    input  logic [4:0]  days_in_month_i,
    input  logic        hour_tick_i,
    input  logic        alarm_raw_i,
    output logic        alarm_o,
    output logic        hour_add_o,
    output logic        hour_hold_o,
    output logic        summer_time_enable_o,
    output logic        binary_format_select_o,
    output logic        hour_12_mode_o,
    output logic        irq_o
);

    typedef struct packed {
        logic [7:0]  wday;
        rwd_shift_t  fwd;
        rwd_shift_t  bwd;
        logic [2:0]  ctrl;
        logic [2:0]  stat;
        logic [2:0]  ien;
        logic [31:0] prdata;
        rwd_fb_t     fb;
        logic        alarm;
    } rwd_st_t;

    rwd_st_t q_ff;
    rwd_st_t nxt_q;

    rwd_cal_if cal ();

    logic        fwd_match;
    logic        bwd_match;
    logic        setup;
    logic        access;
    logic        wr;
    logic        mapped;
    logic [31:0] rd;
    logic        ste;
    logic        wday_ok;
    logic        qualified;
    logic [2:0]  ev;
    logic [2:0]  clr;

    function automatic logic [31:0] shift_rd(input rwd_shift_t s);
        logic [31:0] r;
        r                                  = '0;
        r[RWD_MER_POS]                     = s.mer;
        r[RWD_HOUR_LSB+:7]                 = s.hour;
        r[RWD_WEEK_LSB+:3]                 = s.week;
        r[RWD_DOW_LSB+:3]                  = s.dow;
        r[7:0]                             = s.month;
        return r;
    endfunction : shift_rd

    function automatic rwd_shift_t shift_wr(input rwd_shift_t s, input logic [31:0] d,
                                           input logic [3:0] strb, input logic [2:0] ctrl);
        rwd_shift_t r;
        r = s;
        if (strb[3]) begin
            r.mer  = d[RWD_MER_POS];
            r.hour = d[RWD_HOUR_LSB+:7];
        end
        if (strb[2]) begin
            r.week = d[RWD_WEEK_LSB+:3];
        end
        if (strb[1]) begin
            r.dow = d[RWD_DOW_LSB+:3];
        end
        if (strb[0]) begin
            r.month = d[7:0];
        end
        // formats frozen at write so later mode changes leave values alone
        r.fmt_bin = ctrl[RWD_CTL_BIN];
        r.fmt_12h = ctrl[RWD_CTL_12H];
        return r;
    endfunction : shift_wr

    rwd_calc u_calc (
        .hours_i         (hours_i),
        .month_i         (month_i),
        .dow_i           (dow_i),
        .mday_i          (mday_i),
        .days_in_month_i (days_in_month_i),
        .bin_i           (q_ff.ctrl[RWD_CTL_BIN]),
        .h12_i           (q_ff.ctrl[RWD_CTL_12H]),
        .cal             (cal.calc)
    );

    rwd_shift_match u_fwd (
        .cfg_i   (q_ff.fwd),
        .cal     (cal.match),
        .match_o (fwd_match)
    );

    rwd_shift_match u_bwd (
        .cfg_i   (q_ff.bwd),
        .cal     (cal.match),
        .match_o (bwd_match)
    );

    // zero wait states; read data captured in the setup phase
    assign setup    = psel_i && !penable_i;
    assign access   = psel_i && penable_i;
    assign wr       = access && pwrite_i;
    assign pready_o = 1'b1;

    always_comb begin
        mapped = 1'b1;
        rd     = '0;
        if (paddr_i == RWD_OFF_WDAY) begin
            rd[7:0] = q_ff.wday;
        end else if (paddr_i == RWD_OFF_FWD) begin
            rd = shift_rd(q_ff.fwd);
        end else if (paddr_i == RWD_OFF_BWD) begin
            rd = shift_rd(q_ff.bwd);
        end else if (paddr_i == RWD_OFF_CTRL) begin
            rd[2:0] = q_ff.ctrl;
        end else if (paddr_i == RWD_OFF_STAT) begin
            rd[2:0] = q_ff.stat;
        end else if (paddr_i == RWD_OFF_CLR) begin
            rd = '0;
        end else if (paddr_i == RWD_OFF_IEN) begin
            rd[2:0] = q_ff.ien;
        end else begin
            mapped = 1'b0;
        end
    end

    assign pslverr_o = access && !mapped;
    assign prdata_o  = q_ff.prdata;

    assign ste = q_ff.ctrl[RWD_CTL_STE];

    // weekday gate: only 1..7 restricts, wildcard and others pass
    assign wday_ok = (q_ff.wday == 8'h00) || (q_ff.wday > 8'h07) || (q_ff.wday[2:0] == dow_i);

    // extra hour jumps the counter past the whole skipped hour, so no
    // alarm inside it can match; the tick cycle itself is also masked
    // because the counter may show the skipped hour for one cycle
    assign hour_add_o = ste && hour_tick_i && fwd_match;
    assign qualified  = alarm_raw_i && wday_ok && !hour_add_o;

    // the repeated hour is not masked, so its alarm fires twice
    assign hour_hold_o = ste && hour_tick_i && bwd_match && (q_ff.fb == RWD_FB_ARMED);

    assign ev = {hour_hold_o, hour_add_o, qualified};
    assign clr = (wr && (paddr_i == RWD_OFF_CLR)) ? pwdata_i[2:0] : 3'h0;

    always_comb begin
        nxt_q = q_ff;
        if (setup) begin
            nxt_q.prdata = rd;
        end
        if (wr && (paddr_i == RWD_OFF_WDAY) && pstrb_i[0]) begin
            if (pwdata_i[7:6] == RWD_WILD_TOP) begin
                nxt_q.wday = RWD_WDAY_RST;
            end else begin
                nxt_q.wday = pwdata_i[7:0];
            end
        end
        if (wr && (paddr_i == RWD_OFF_FWD)) begin
            nxt_q.fwd = shift_wr(q_ff.fwd, pwdata_i, pstrb_i, q_ff.ctrl);
        end
        if (wr && (paddr_i == RWD_OFF_BWD)) begin
            nxt_q.bwd = shift_wr(q_ff.bwd, pwdata_i, pstrb_i, q_ff.ctrl);
        end
        if (wr && (paddr_i == RWD_OFF_CTRL) && pstrb_i[0]) begin
            nxt_q.ctrl = pwdata_i[2:0];
        end
        if (wr && (paddr_i == RWD_OFF_IEN) && pstrb_i[0]) begin
            nxt_q.ien = pwdata_i[2:0];
        end
        // a new event wins over a clear in the same cycle
        nxt_q.stat  = (q_ff.stat & ~clr) | ev;
        nxt_q.alarm = qualified;
        case (q_ff.fb)
            RWD_FB_ARMED: begin
                if (hour_hold_o) begin
                    nxt_q.fb = RWD_FB_HOLD;
                end
            end
            RWD_FB_HOLD: begin
                // the repeated hour's end tick is skipped, then re-arm
                if (!ste || hour_tick_i) begin
                    nxt_q.fb = RWD_FB_ARMED;
                end
            end
            default: begin
                nxt_q.fb = RWD_FB_ARMED;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q_ff        <= '0;
            q_ff.wday   <= RWD_WDAY_RST;
            q_ff.fwd    <= RWD_SHIFT_RST;
            q_ff.bwd    <= RWD_SHIFT_RST;
            q_ff.ctrl   <= RWD_CTRL_RST;
            q_ff.fb     <= RWD_FB_ARMED;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign alarm_o                = q_ff.alarm;
    assign irq_o                  = |(q_ff.stat & q_ff.ien);
    assign summer_time_enable_o   = ste;
    assign binary_format_select_o = q_ff.ctrl[RWD_CTL_BIN];
    assign hour_12_mode_o         = q_ff.ctrl[RWD_CTL_12H];

    // software keeps fields valid and clears enable before byte writes;
    // the block relies on that and does not shadow partial writes

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    sequence s_hold_enter;
        hour_hold_o ##1 (q_ff.fb == RWD_FB_HOLD);
    endsequence

    sequence s_wild_write;
        wr && (paddr_i == RWD_OFF_WDAY) && pstrb_i[0] && (pwdata_i[7:6] == RWD_WILD_TOP);
    endsequence

    a_wild_readback: assert property (s_wild_write |=> q_ff.wday == RWD_WDAY_RST)
        else $error("wildcard write did not read back as ff");

    a_wday_gate: assert property ((alarm_raw_i && (q_ff.wday >= 8'h01) && (q_ff.wday <= 8'h07)
                                   && (q_ff.wday[2:0] != dow_i)) |=> !alarm_o)
        else $error("alarm passed on a wrong weekday");

    a_alarm_cause: assert property (alarm_o |-> $past(alarm_raw_i) && q_ff.stat[RWD_EV_ALARM])
        else $error("alarm without raw alarm or status");

    a_add_status: assert property (hour_add_o |=> q_ff.stat[RWD_EV_FWD])
        else $error("extra hour did not set status");

    a_hold_enter: assert property (hour_hold_o |-> s_hold_enter)
        else $error("fall-back did not disarm");

    a_hold_once: assert property (s_hold_enter |-> (!hour_hold_o until hour_tick_i))
        else $error("fall-back retriggered while disarmed");

    a_rearm_bound: assert property ((q_ff.fb == RWD_FB_HOLD && ste && hour_tick_i) |=> q_ff.fb == RWD_FB_ARMED)
        else $error("fall-back did not re-arm");

    a_byte_write: assert property ((wr && paddr_i == RWD_OFF_FWD && pstrb_i == 4'h4)
                                   |=> q_ff.fwd.week == $past(pwdata_i[RWD_WEEK_LSB+:3])
                                       && q_ff.fwd.hour == $past(q_ff.fwd.hour))
        else $error("byte write to spring-shift went wrong");

    a_fmt_capture: assert property ((wr && paddr_i == RWD_OFF_FWD)
                                    |=> q_ff.fwd.fmt_bin == $past(q_ff.ctrl[RWD_CTL_BIN]))
        else $error("format not captured at write");

    a_off_quiet: assert property (!ste |-> !hour_add_o && !hour_hold_o)
        else $error("shift acted with enable clear");

    a_skip_mask: assert property ((hour_add_o && alarm_raw_i) |=> !alarm_o)
        else $error("alarm fired in skipped hour tick");

    a_rdata_capture: assert property (setup |=> prdata_o == $past(rd))
        else $error("read data not captured in setup");

    a_unmapped_quiet: assert property ((wr && !mapped)
                                       |=> q_ff.wday == $past(q_ff.wday) && q_ff.ctrl == $past(q_ff.ctrl))
        else $error("unmapped write changed a register");

    a_stat_readonly: assert property ((wr && paddr_i == RWD_OFF_STAT && ev == 3'h0)
                                      |=> q_ff.stat == $past(q_ff.stat))
        else $error("status took a write");

    sequence s_clr_write;
        wr && (paddr_i == RWD_OFF_CLR);
    endsequence

    a_clr_effect: assert property ((s_clr_write ##0 (pwdata_i[RWD_EV_FWD] && !hour_add_o))
                                   |=> !q_ff.stat[RWD_EV_FWD])
        else $error("clear left the spring status set");

    a_alarm_status: assert property (qualified |=> q_ff.stat[RWD_EV_ALARM])
        else $error("qualified alarm did not set status");

    a_hold_status: assert property (hour_hold_o |=> q_ff.stat[RWD_EV_BWD])
        else $error("fall-back did not set status");

    a_irq_quiet: assert property ((q_ff.ien == 3'h0) |-> !irq_o)
        else $error("interrupt raised with all enables clear");

    a_wday_store: assert property ((wr && paddr_i == RWD_OFF_WDAY && pstrb_i[0]
                                    && pwdata_i[7:6] != RWD_WILD_TOP) |=> q_ff.wday == $past(pwdata_i[7:0]))
        else $error("weekday value not stored");

    a_ctrl_store: assert property ((wr && paddr_i == RWD_OFF_CTRL && pstrb_i[0])
                                   |=> q_ff.ctrl == $past(pwdata_i[2:0]))
        else $error("control value not stored");

    a_wild_pass: assert property ((alarm_raw_i && !hour_add_o && q_ff.wday == RWD_WDAY_RST)
                                  |=> alarm_o)
        else $error("wildcard weekday blocked the alarm");

    a_dow_pass: assert property ((alarm_raw_i && !hour_add_o && q_ff.wday[2:0] == dow_i)
                                 |=> alarm_o)
        else $error("alarm blocked on the matching weekday");

    a_fwd_hour_lane: assert property ((wr && paddr_i == RWD_OFF_FWD && pstrb_i[3])
                                      |=> q_ff.fwd.hour == $past(pwdata_i[RWD_HOUR_LSB+:7])
                                          && q_ff.fwd.mer == $past(pwdata_i[RWD_MER_POS]))
        else $error("hour lane of spring-shift not stored");

    a_bwd_week_lane: assert property ((wr && paddr_i == RWD_OFF_BWD && pstrb_i[2])
                                      |=> q_ff.bwd.week == $past(pwdata_i[RWD_WEEK_LSB+:3]))
        else $error("week lane of fall-back not stored");

    a_bwd_fmt: assert property ((wr && paddr_i == RWD_OFF_BWD)
                                |=> q_ff.bwd.fmt_bin == $past(q_ff.ctrl[RWD_CTL_BIN])
                                    && q_ff.bwd.fmt_12h == $past(q_ff.ctrl[RWD_CTL_12H]))
        else $error("fall-back format not captured at write");

    a_fwd_12h: assert property ((wr && paddr_i == RWD_OFF_FWD)
                                |=> q_ff.fwd.fmt_12h == $past(q_ff.ctrl[RWD_CTL_12H]))
        else $error("hour mode not captured at write");

    a_rearm_off: assert property ((q_ff.fb == RWD_FB_HOLD && !ste) |=> q_ff.fb == RWD_FB_ARMED)
        else $error("fall-back did not re-arm on enable clear");

    a_fb_onehot: assert property ($onehot(q_ff.fb))
        else $error("fall-back state not one-hot");

endmodule : rwd_top

// ===== pkg/rwd_pkg.sv
// Overview of operation
// - weekday alarm field 1..7 blocks the alarm unless day-of-week matches
// - write with top bits 11 makes wildcard, reads ff; reset ff
// - meridiem bit 31 compared to hours bit 7 if 12-hour at write
// - bits 30:24 hold hour compare, decoded with formats at write time
// - bits 18:16 select week of month, 1..4 nth week, 5 last
// - bits 10:8 compared against day-of-week bits 2:0
// - bits 7:0 compared against the whole month counter
// - shift registers accept full-word and single-byte writes
// - with enable set, matching spring-shift adds one extra hour
// - no field is a wildcard; software keeps every field valid
// - binary/bcd taken at write; later format changes do not alter
// - alarm inside the skipped hour never fires
// - fall-back register uses the same meridiem and hour layout
// - fall-back match suppresses one increment, disarms, re-arms itself
// - fall-back week, weekday and month fields mirror spring-shift
// - alarm in the repeated hour fires twice
package rwd_pkg;

    localparam logic [7:0] RWD_OFF_WDAY = 8'h14;
    localparam logic [7:0] RWD_OFF_FWD  = 8'h18;
    localparam logic [7:0] RWD_OFF_BWD  = 8'h1c;
    localparam logic [7:0] RWD_OFF_CTRL = 8'h20;
    localparam logic [7:0] RWD_OFF_STAT = 8'h24;
    localparam logic [7:0] RWD_OFF_CLR  = 8'h28;
    localparam logic [7:0] RWD_OFF_IEN  = 8'h2c;

    localparam int RWD_MER_POS  = 31;
    localparam int RWD_HOUR_LSB = 24;
    localparam int RWD_WEEK_LSB = 16;
    localparam int RWD_DOW_LSB  = 8;
    localparam int RWD_CTL_STE  = 0;
    localparam int RWD_CTL_BIN  = 1;
    localparam int RWD_CTL_12H  = 2;
    localparam int RWD_EV_ALARM = 0;
    localparam int RWD_EV_FWD   = 1;
    localparam int RWD_EV_BWD   = 2;

    localparam logic [7:0] RWD_WDAY_RST  = 8'hff;
    localparam logic [1:0] RWD_WILD_TOP  = 2'h3;
    localparam logic [2:0] RWD_WEEK_LAST = 3'h5;
    localparam logic [2:0] RWD_CTRL_RST  = 3'h0;
    localparam logic [4:0] RWD_HOUR_MAX  = 5'h17;
    localparam logic [4:0] RWD_WEEK_DAYS = 5'h07;

    typedef struct packed {
        logic       mer;
        logic [6:0] hour;
        logic [2:0] week;
        logic [2:0] dow;
        logic [7:0] month;
        logic       fmt_bin;
        logic       fmt_12h;
    } rwd_shift_t;

    localparam rwd_shift_t RWD_SHIFT_RST = '0;

    typedef enum logic [1:0] {
        RWD_FB_ARMED = 2'b01,
        RWD_FB_HOLD  = 2'b10
    } rwd_fb_t;

    function automatic logic [7:0] rwd_to_bin(input logic [7:0] v, input logic bin);
        return bin ? v : 8'({4'h0, v[7:4]} * 8'h0a + {4'h0, v[3:0]});
    endfunction : rwd_to_bin

    function automatic logic [4:0] rwd_hour24(input logic [7:0] h, input logic bin, input logic h12);
        logic [7:0] v;
        v = rwd_to_bin({1'b0, h[6:0]}, bin);
        if (h12) begin
            if (v == 8'h0c) begin
                v = 8'h00;
            end
            if (h[7]) begin
                v = 8'(v + 8'h0c);
            end
        end
        return v[4:0];
    endfunction : rwd_hour24

endpackage : rwd_pkg

// ===== pkg/rwd_cal_if.sv
interface rwd_cal_if;
    logic [4:0] next_hour;
    logic [7:0] month;
    logic [2:0] dow;
    logic [2:0] week;
    logic       last;
    modport calc  (output next_hour, month, dow, week, last);
    modport match (input  next_hour, month, dow, week, last);
endinterface : rwd_cal_if

// ===== rtl/rwd_calc.sv
module rwd_calc
    import rwd_pkg::*;
(
    input  logic [7:0]  hours_i,
    input  logic [7:0]  month_i,
    input  logic [2:0]  dow_i,
    input  logic [7:0]  mday_i,
    input  logic [4:0]  days_in_month_i,
    input  logic        bin_i,
    input  logic        h12_i,
    rwd_cal_if.calc     cal
);
    logic [4:0] cur_h;
    logic [4:0] md;

    always_comb begin
        cur_h         = rwd_hour24(hours_i, bin_i, h12_i);
        md            = 5'(rwd_to_bin(mday_i, bin_i));
        cal.next_hour = (cur_h >= RWD_HOUR_MAX) ? 5'h00 : 5'(cur_h + 5'h01);
        cal.month     = rwd_to_bin(month_i, bin_i);
        cal.dow       = dow_i;
        // week of month from day of month, 1..5
        if (md <= 5'h07) begin
            cal.week = 3'h1;
        end else if (md <= 5'h0e) begin
            cal.week = 3'h2;
        end else if (md <= 5'h15) begin
            cal.week = 3'h3;
        end else if (md <= 5'h1c) begin
            cal.week = 3'h4;
        end else begin
            cal.week = 3'h5;
        end
        // last occurrence of this weekday in the month
        cal.last = ({1'b0, md} + {1'b0, RWD_WEEK_DAYS}) > {1'b0, days_in_month_i};
    end
endmodule : rwd_calc

// ===== rtl/rwd_shift_match.sv
module rwd_shift_match
    import rwd_pkg::*;
(
    input  rwd_shift_t  cfg_i,
    rwd_cal_if.match    cal,
    output logic        match_o
);
    logic hour_ok;
    logic week_ok;
    logic month_ok;
    logic dow_ok;

    always_comb begin
        // stored formats, not the current ones, decode the fields
        hour_ok  = rwd_hour24({cfg_i.mer, cfg_i.hour}, cfg_i.fmt_bin, cfg_i.fmt_12h) == cal.next_hour;
        month_ok = rwd_to_bin(cfg_i.month, cfg_i.fmt_bin) == cal.month;
        dow_ok   = cfg_i.dow == cal.dow;
        // no wildcard: week 0 or 6..7 never matches
        if (cfg_i.week == RWD_WEEK_LAST) begin
            week_ok = cal.last;
        end else begin
            week_ok = (cfg_i.week != 3'h0) && (cfg_i.week == cal.week);
        end
        match_o = hour_ok && month_ok && dow_ok && week_ok;
    end
endmodule : rwd_shift_match

// ===== tb/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rwd_pkg::*;

    typedef struct packed {
        logic [2:0]  kind;
        logic [32:0] val;
    } rwd_note_t;

    logic        clk_i           = 1'b0;
    logic        nrst_i          = 1'b0;
    logic        psel_i          = 1'b0;
    logic        penable_i       = 1'b0;
    logic        pwrite_i        = 1'b0;
    logic [7:0]  paddr_i         = 8'h00;
    logic [31:0] pwdata_i        = 32'h0;
    logic [3:0]  pstrb_i         = 4'h0;
    logic [7:0]  hours_i         = 8'h00;
    logic [7:0]  month_i         = 8'h01;
    logic [2:0]  dow_i           = 3'h1;
    logic [7:0]  mday_i          = 8'h01;
    logic [4:0]  days_in_month_i = 5'h1f;
    logic        hour_tick_i     = 1'b0;
    logic        alarm_raw_i     = 1'b0;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        alarm_o;
    logic        hour_add_o;
    logic        hour_hold_o;
    logic        irq_o;
    logic        summer_time_enable_o;
    logic        binary_format_select_o;
    logic        hour_12_mode_o;
    logic        probe           = 1'b0;
    logic        raw_d           = 1'b0;
    rwd_note_t   exp_q[$];
    int          err_total       = 0;
    int          cmp_count       = 0;
    int          cyc             = 0;

    rwd_top u_rwd_top (.clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
        .prdata_o, .pready_o, .pslverr_o, .hours_i, .month_i, .dow_i, .mday_i, .days_in_month_i,
        .hour_tick_i, .alarm_raw_i, .alarm_o, .hour_add_o, .hour_hold_o, .summer_time_enable_o,
        .binary_format_select_o, .hour_12_mode_o, .irq_o);

    always #10 clk_i = ~clk_i;

    task automatic note(input logic [2:0] k, input logic [32:0] v);
        exp_q.push_back('{kind: k, val: v});
    endtask : note

    task automatic stop_test();
        if (exp_q.size() != 0) err_total++;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [2:0] k, input logic [32:0] g);
        rwd_note_t e;
        cmp_count++;
        if (exp_q.size() == 0) begin
            err_total++;
            $display("ERROR t=%0t unexpected result kind %0d", $time, k);
        end else begin
            e = exp_q.pop_front();
            if (e.kind !== k || e.val !== g) begin
                err_total++;
                $display("ERROR t=%0t kind %0d got %h exp %h", $time, k, g, e.val);
            end
        end
    endtask : check

    // monitor: pops the oldest note whenever a result shows
    always @(posedge clk_i) begin
        raw_d <= alarm_raw_i;
        if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i) begin
            if (exp_q.size() > 0 && exp_q[0].kind == 3'd4) check(3'd4, {pslverr_o, 32'h0});
            else check(3'd0, {pslverr_o, prdata_o});
        end
        if (hour_tick_i) check(3'd1, {31'h0, hour_hold_o, hour_add_o});
        if (raw_d) check(3'd2, {32'h0, alarm_o});
        if (probe) check(3'd3, {29'h0, hour_12_mode_o, binary_format_select_o, summer_time_enable_o, irq_o});
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            $display("ERROR t=%0t run did not finish", $time);
            stop_test();
        end
    end

    // one idle edge after release, so a new setup never lands in the same step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        if (!wr) note(a == 8'h40 ? 3'd4 : 3'd0, {a == 8'h40, a == 8'h40 ? 32'h0 : d});
        psel_i    <= 1'b1;
        pwrite_i  <= wr;
        paddr_i   <= a;
        pwdata_i  <= d;
        pstrb_i   <= s;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1) @(posedge clk_i);
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, e, 4'hf);
    endtask : rd

    task automatic tick(input logic [7:0] h, mo, md, input logic [2:0] dw, input logic add, hold, al, ae);
        hours_i     <= h;
        month_i     <= mo;
        mday_i      <= md;
        dow_i       <= dw;
        hour_tick_i <= 1'b1;
        alarm_raw_i <= al;
        note(3'd1, {31'h0, hold, add});
        if (al) note(3'd2, {32'h0, ae});
        @(posedge clk_i);
        hour_tick_i <= 1'b0;
        alarm_raw_i <= 1'b0;
        @(posedge clk_i);
    endtask : tick

    task automatic irq_chk(input logic [2:0] c, input logic e);
        probe <= 1'b1;
        note(3'd3, {29'h0, c, e});
        @(posedge clk_i);
        probe <= 1'b0;
        @(posedge clk_i);
    endtask : irq_chk

    initial begin
        int         w;
        logic [7:0] md;
        logic [4:0] dim;
        logic [2:0] dw;
        logic       a;
        void'($urandom(73645));
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        rd(RWD_OFF_WDAY, 32'hff);
        rd(RWD_OFF_FWD, 32'h0);
        rd(RWD_OFF_BWD, 32'h0);
        rd(RWD_OFF_CTRL, 32'h0);
        wr(RWD_OFF_STAT, 32'hff);
        rd(RWD_OFF_STAT, 32'h0);
        rd(8'h40, 32'h0);
        wr(8'h40, 32'hffffffff);
        $display("test reset done");
        wr(RWD_OFF_WDAY, {24'h0, 2'h3, 6'($urandom)});
        rd(RWD_OFF_WDAY, 32'hff);
        for (w = 1; w <= 7; w++) begin
            wr(RWD_OFF_WDAY, 32'(w));
            rd(RWD_OFF_WDAY, 32'(w));
            dw = 3'($urandom_range(7, 1));
            tick(8'h01, 8'h01, 8'h01, dw, 1'b0, 1'b0, 1'b1, dw == w);
            tick(8'h01, 8'h01, 8'h01, 3'(w), 1'b0, 1'b0, 1'b1, 1'b1);
        end
        wr(RWD_OFF_WDAY, 32'hff);
        $display("test weekday done");
        wr(RWD_OFF_CLR, 32'h7);
        wr(RWD_OFF_CTRL, 32'h2);
        wr(RWD_OFF_FWD, 32'h02010703);
        rd(RWD_OFF_FWD, 32'h02010703);
        for (w = 0; w <= 7; w++) begin
            wr(RWD_OFF_CTRL, 32'h2);
            apb(1'b1, RWD_OFF_FWD, 32'(w) << 16, 4'h4);
            wr(RWD_OFF_CTRL, 32'h3);
            dim = 5'($urandom_range(31, 28));
            md = 8'($urandom_range(dim, 1));
            days_in_month_i <= dim;
            a = (w == 1 + (md - 1) / 7) || (w == 5 && md + 7 > dim);
            tick(8'h01, 8'h03, md, 3'h7, a, 1'b0, 1'b1, !a);
        end
        rd(RWD_OFF_FWD, 32'h02070703);
        wr(RWD_OFF_CTRL, 32'h2);
        wr(RWD_OFF_FWD, 32'h02010703);
        wr(RWD_OFF_CTRL, 32'h3);
        tick(8'h01, 8'h03, 8'h01, 3'h7, 1'b1, 1'b0, 1'b1, 1'b0);
        tick(8'h02, 8'h03, 8'h01, 3'h7, 1'b0, 1'b0, 1'b1, 1'b1);
        tick(8'h01, 8'h04, 8'h01, 3'h7, 1'b0, 1'b0, 1'b1, 1'b1);
        tick(8'h01, 8'h03, 8'h01, 3'h6, 1'b0, 1'b0, 1'b1, 1'b1);
        wr(RWD_OFF_CTRL, 32'h2);
        tick(8'h01, 8'h03, 8'h01, 3'h7, 1'b0, 1'b0, 1'b1, 1'b1);
        $display("test spring shift done");
        rd(RWD_OFF_STAT, 32'h3);
        wr(RWD_OFF_IEN, 32'h4);
        irq_chk(3'h2, 1'b0);
        wr(RWD_OFF_IEN, 32'h2);
        irq_chk(3'h2, 1'b1);
        wr(RWD_OFF_CLR, 32'h2);
        irq_chk(3'h2, 1'b0);
        rd(RWD_OFF_STAT, 32'h1);
        rd(RWD_OFF_CLR, 32'h0);
        rd(RWD_OFF_IEN, 32'h2);
        wr(RWD_OFF_CLR, 32'h1);
        $display("test interrupt done");
        wr(RWD_OFF_BWD, 32'h0505010a);
        wr(RWD_OFF_CTRL, 32'h3);
        days_in_month_i <= 5'h1f;
        // repeated hour: second pass must not hold again, alarm fires both times
        tick(8'h04, 8'h0a, 8'h1d, 3'h1, 1'b0, 1'b1, 1'b1, 1'b1);
        tick(8'h04, 8'h0a, 8'h1d, 3'h1, 1'b0, 1'b0, 1'b1, 1'b1);
        tick(8'h05, 8'h0a, 8'h1d, 3'h1, 1'b0, 1'b0, 1'b0, 1'b0);
        tick(8'h04, 8'h0a, 8'h1d, 3'h1, 1'b0, 1'b1, 1'b0, 1'b0);
        rd(RWD_OFF_STAT, 32'h5);
        $display("test fall back done");
        // stored in 12h bcd, matched later under 24h binary
        wr(RWD_OFF_CTRL, 32'h4);
        irq_chk(3'h4, 1'b0);
        wr(RWD_OFF_FWD, 32'h81010210);
        wr(RWD_OFF_CTRL, 32'h3);
        tick(8'h0c, 8'h0a, 8'h01, 3'h2, 1'b1, 1'b0, 1'b0, 1'b0);
        tick(8'h00, 8'h0a, 8'h01, 3'h2, 1'b0, 1'b0, 1'b0, 1'b0);
        irq_chk(3'h3, 1'b1);
        wr(RWD_OFF_CTRL, 32'h0);
        $display("test format done");
        stop_test();
    end

endmodule : tb_top
